//--- shared/mpfs_pkg.sv
// constants and types shared by the program flow sequencer
package mpfs_pkg;

	// ****************************************
	// time base
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	// conditional branches settle this many whole ms before sampling
	localparam int COND_LAG_MS = 2;

	// ****************************************
	// operand and table sizes
	// ****************************************
	localparam int LABEL_W = 6;
	localparam int SUB_IDX_W = 5;
	localparam int JUMP_LABELS = 63;
	localparam int SUB_LABELS = 19;
	localparam int CALL_DEPTH = 3;
	localparam int LOOP_DEPTH = 3;
	localparam int DEPTH_W = 2;
	localparam int LOOP_W = 8;
	localparam int TIME_W = 16;
	localparam int POS_W = 32;
	localparam int SPD_W = 4;

	// ****************************************
	// command set and sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		OP_NOP,
		OP_INPUT_COND_BRANCH,
		OP_POSITION_COND_BRANCH,
		OP_UNCOND_BRANCH,
		OP_SUB_CALL,
		OP_SUB_RETURN,
		OP_LOOP_BEGIN,
		OP_LOOP_CLOSE,
		OP_PROG_END,
		OP_TIMER
	} mpfs_op_t;

	typedef enum logic [2:0] {
		S_IDLE,
		S_ISSUE,
		S_FETCH,
		S_EXEC,
		S_WAIT,
		S_COND,
		S_STOP,
		S_FINISH
	} mpfs_state_t;

endpackage

//--- verification/motion_program_flow_sequencer_tb_top.sv
// self-checking bench of the program flow sequencer
`timescale 1ns/100ps
module motion_program_flow_sequencer_tb_top;
	localparam int CP = 20;
	logic ref_clk = 0, rst = 1, start = 0, label_wr = 0, label_is_sub = 0;
	logic [7:0] start_line = 0, label_line = 0, in_ports = 0, prog_addr_reg;
	logic [5:0] label_num = 0, instr_label;
	logic [3:0] speed_sel_in = 0, sp, v, speed_saved_reg;
	logic signed [31:0] cur_pos = 0, instr_pos;
	logic motor_rotating = 0, dir_positive = 0, slow = 0, saw_decel, err, e;
	logic instr_valid, instr_level, running_reg, fetch_req_reg, decel_stop_req_reg;
	logic speed_restore_reg, nest_error_reg, prog_done_reg;
	mpfs_pkg::mpfs_op_t instr_op;
	logic [2:0] instr_port;
	logic [15:0] instr_arg;
	logic [31:0] tg;
	int n_mismatch = 0, check_count = 0, k, t, n, d, c1, c2, c3;

	mpfs_sequencer #(.CYC_PER_MS(CP)) dut_u (.ref_clk, .rst, .start, .start_line,
		.instr_valid, .instr_op, .instr_port, .instr_level, .instr_label, .instr_arg,
		.instr_pos, .label_wr, .label_is_sub, .label_num, .label_line, .in_ports,
		.cur_pos, .motor_rotating, .dir_positive, .speed_sel_in, .running_reg,
		.prog_addr_reg, .fetch_req_reg, .decel_stop_req_reg, .speed_restore_reg,
		.speed_saved_reg, .nest_error_reg, .prog_done_reg);
	mpfs_prog_model pm (.ref_clk, .slow, .fetch_req_reg, .prog_addr_reg, .instr_valid,
		.instr_op, .instr_port, .instr_level, .instr_label, .instr_arg, .instr_pos);

	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;

	// the drive halts one cycle after a decelerating stop is asked for
	always @(posedge ref_clk)
		if (decel_stop_req_reg === 1'b1)
		begin
			saw_decel <= 1;
			motor_rotating <= #1 0;
		end

	// ****************
	// shared tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask

	// expected branch outcomes worked out from the branch rules
	function automatic logic exp_in(input logic [7:0] p, input logic [3:0] c);
		return p[c[2:0]] == c[3];
	endfunction

	function automatic logic exp_pos(input logic signed [31:0] p, input logic signed [31:0] g,
		input logic rot, input logic dir);
		return rot && (dir ? p > g : p < g);
	endfunction

	task automatic ld(input int a, input mpfs_pkg::mpfs_op_t o, input logic [5:0] l,
		input logic [31:0] x);
		pm.op[a] = o;
		pm.lb[a] = l;
		pm.arg[a] = x[15:0];
		pm.ps[a] = x;
	endtask

	// label_wr stays high across back-to-back entries
	task automatic lab(input logic s, input logic [5:0] nm, input logic [7:0] l);
		label_is_sub = s;
		label_num = nm;
		label_line = l;
		label_wr = 1;
		@(posedge ref_clk);
		#1;
	endtask

	// start at a line, wait for the end pulse, check the speed restore
	task automatic run(input logic [7:0] a);
		foreach (pm.hits[i]) pm.hits[i] = 0;
		sp = $urandom;
		speed_sel_in = sp;
		start_line = a;
		slow = $urandom;
		saw_decel = 0;
		start = 1;
		@(posedge ref_clk);
		#1;
		start = 0;
		speed_sel_in = ~sp;
		chk("running at start", 1, {31'h0, running_reg});
		for (k = 0; k < 30000 && prog_done_reg !== 1'b1; k++)
		begin
			@(posedge ref_clk);
			#1;
		end
		if (k == 30000)
		begin
			n_mismatch++;
			results();
		end
		chk("saved speed", {28'h0, sp}, {28'h0, speed_saved_reg});
		chk("speed restore", 1, {31'h0, speed_restore_reg});
		chk("running at end", 0, {31'h0, running_reg});
		err = nest_error_reg;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic results();
		$display("mismatches %0d of %0d comparisons", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ****************
	// main sequence
	// ****************
	initial
	begin
		t = $urandom(23);
		repeat (20) @(posedge ref_clk);
		#1 rst = 0;
		lab(0, 1, 10); lab(0, 63, 63); lab(0, 3, 66); lab(0, 4, 64); lab(0, 5, 73);
		lab(1, 1, 20); lab(1, 2, 24); lab(1, 19, 28); lab(1, 4, 40);
		label_wr = 0;
		// program image: labels 1..63, closes after begins, each program ends
		ld(4, mpfs_pkg::OP_LOOP_CLOSE, 0, 0);
		ld(5, mpfs_pkg::OP_LOOP_CLOSE, 0, 0);
		ld(6, mpfs_pkg::OP_LOOP_CLOSE, 0, 0);
		ld(7, mpfs_pkg::OP_SUB_CALL, 1, 0);
		ld(8, mpfs_pkg::OP_UNCOND_BRANCH, 1, 0);
		ld(10, mpfs_pkg::OP_PROG_END, 0, 0);
		ld(20, mpfs_pkg::OP_SUB_CALL, 2, 0);
		ld(21, mpfs_pkg::OP_SUB_RETURN, 0, 0);
		ld(24, mpfs_pkg::OP_SUB_CALL, 19, 0);
		ld(25, mpfs_pkg::OP_SUB_RETURN, 0, 0);
		ld(29, mpfs_pkg::OP_SUB_RETURN, 0, 0);
		ld(40, mpfs_pkg::OP_SUB_CALL, 4, 0);
		for (t = 44; t < 48; t++) ld(t, mpfs_pkg::OP_LOOP_BEGIN, 0, 2);
		ld(48, mpfs_pkg::OP_SUB_RETURN, 0, 0);
		ld(62, mpfs_pkg::OP_PROG_END, 0, 0);
		ld(63, mpfs_pkg::OP_PROG_END, 0, 0);
		ld(64, mpfs_pkg::OP_INPUT_COND_BRANCH, 3, 8);
		ld(65, mpfs_pkg::OP_UNCOND_BRANCH, 4, 0);
		ld(66, mpfs_pkg::OP_PROG_END, 0, 0);
		ld(72, mpfs_pkg::OP_PROG_END, 0, 0);
		ld(73, mpfs_pkg::OP_PROG_END, 0, 0);
		ld(81, mpfs_pkg::OP_PROG_END, 0, 0);
		// nested loops, last round with the 255 and 1 count limits
		for (t = 0; t < 4; t++)
		begin
			c1 = t == 3 ? 255 : $urandom_range(4, 1);
			c2 = t == 3 ? 1 : $urandom_range(4, 1);
			c3 = t == 3 ? 1 : $urandom_range(4, 1);
			ld(0, mpfs_pkg::OP_LOOP_BEGIN, 0, c1);
			ld(1, mpfs_pkg::OP_LOOP_BEGIN, 0, c2);
			ld(2, mpfs_pkg::OP_LOOP_BEGIN, 0, c3);
			run(0);
			chk("loop body", c1 * c2 * c3, pm.hits[3]);
			chk("deepest sub", 1, pm.hits[28]);
			chk("after call", 1, pm.hits[8]);
			chk("skipped line", 0, pm.hits[9]);
			chk("nest error", 0, {31'h0, err});
		end
		// one call or loop too deep, and a return with nothing to return to
		for (t = 40; t < 49; t += 4)
		begin
			run(t[7:0]);
			chk("nest overflow", 1, {31'h0, err});
			if (t == 40)
				chk("call depth", 4, pm.hits[40]);
		end
		// input branch on random ports and levels
		for (t = 0; t < 6; t++)
		begin
			in_ports = $urandom;
			v = $urandom_range(15, 0);
			ld(60, mpfs_pkg::OP_INPUT_COND_BRANCH, 63, v);
			e = exp_in(in_ports, v);
			run(60);
			chk("input branch", e, pm.hits[63]);
			chk("input next line", !e, pm.hits[61]);
		end
		// polling loop released by the input some milliseconds later
		in_ports = 0;
		fork
			run(64);
			begin
				repeat (300) @(posedge ref_clk);
				#1 in_ports = 8'h01;
			end
		join
		chk("poll rounds", 1, pm.hits[64] > 2);
		chk("poll exit", 1, pm.hits[66]);
		// position branch: signed extremes, equal, one past, stopped motor
		for (t = 0; t < 10; t++)
		begin
			cur_pos = t == 0 ? 32'h7fffffff : t == 1 ? 32'h80000000 : $urandom;
			tg = t < 2 ? ~cur_pos : cur_pos + $urandom_range(2, 0) - 1;
			motor_rotating = t < 2 || $urandom_range(3, 0) != 0;
			dir_positive = t < 2 ? t == 0 : $urandom;
			e = exp_pos(cur_pos, tg, motor_rotating, dir_positive);
			ld(70, mpfs_pkg::OP_POSITION_COND_BRANCH, 5, tg);
			v = {3'h0, motor_rotating};
			run(70);
			chk("position branch", e, pm.hits[73]);
			chk("decel stop", v, saw_decel);
		end
		// reset in the middle of a timed wait drops the program at once
		ld(80, mpfs_pkg::OP_TIMER, 0, 5);
		start_line = 80;
		start = 1;
		@(posedge ref_clk);
		#1;
		start = 0;
		repeat (30) @(posedge ref_clk);
		#1;
		chk("wait running", 1, {31'h0, running_reg});
		rst = 1;
		#1;
		chk("reset running", 0, {31'h0, running_reg});
		chk("reset line", 0, {24'h0, prog_addr_reg});
		repeat (2) @(posedge ref_clk);
		#1;
		rst = 0;
		// timer waits, the 1 ms minimum first
		for (t = 0; t < 4; t++)
		begin
			n = t == 0 ? 1 : $urandom_range(5, 1);
			ld(80, mpfs_pkg::OP_TIMER, 0, n);
			run(80);
			d = int'((pm.ft[81] - pm.ft[80]) / 10);
			chk("timer wait", 1, d >= n * CP - CP && d <= n * CP + CP);
		end
		results();
	end
endmodule // motion_program_flow_sequencer_tb_top

//--- verification/mpfs_prog_model.sv
// stored program image that answers the sequencer's line fetches
`timescale 1ns/100ps
module mpfs_prog_model (
	input wire logic ref_clk,
	input wire logic slow,
	input wire logic fetch_req_reg,
	input wire logic [7:0] prog_addr_reg,
	output logic instr_valid,
	output mpfs_pkg::mpfs_op_t instr_op,
	output logic [2:0] instr_port,
	output logic instr_level,
	output logic [5:0] instr_label,
	output logic [15:0] instr_arg,
	output logic signed [31:0] instr_pos
);
	mpfs_pkg::mpfs_op_t op [256];
	logic [5:0] lb [256];
	logic [15:0] arg [256];
	logic [31:0] ps [256];
	int hits [256];
	longint ft [256];
	int w;
	logic [7:0] a;

	// ****************
	// fetch answer
	// ****************
	// answers at once or up to three cycles late; between answers the lines
	// carry the inverse of the last line so stale data never looks valid
	initial
	begin
		instr_valid = 0;
		instr_op = mpfs_pkg::OP_NOP;
		{instr_port, instr_level, instr_label, instr_arg, instr_pos} = '0;
		foreach (op[i]) op[i] = mpfs_pkg::OP_NOP;
		forever
		begin
			@(posedge ref_clk);
			#1;
			if (fetch_req_reg === 1'b1)
			begin
				w = slow ? $urandom_range(3, 0) : 0;
				repeat (w)
				begin
					@(posedge ref_clk);
					#1;
				end
				a = prog_addr_reg;
				instr_op = op[a];
				{instr_level, instr_port} = arg[a][3:0];
				instr_label = lb[a];
				instr_arg = arg[a];
				instr_pos = ps[a];
				instr_valid = 1;
				hits[a]++;
				ft[a] = $time;
				@(posedge ref_clk);
				#1;
				instr_valid = 0;
				instr_op = mpfs_pkg::mpfs_op_t'(~instr_op);
				{instr_port, instr_level, instr_label, instr_arg, instr_pos} =
					~{instr_port, instr_level, instr_label, instr_arg, instr_pos};
			end
		end
	end
endmodule // mpfs_prog_model

//--- verilog/mpfs_ms_tick.sv
// millisecond time base with a restart input
`timescale 1ns/100ps
module mpfs_ms_tick #(
	parameter int CYC_PER_MS = mpfs_pkg::CYC_PER_MS
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clr,
	output logic tick_reg
);
	localparam int CNT_W = $clog2(CYC_PER_MS);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYC_PER_MS - 1);

	logic [CNT_W-1:0] cnt_reg;

	// restart aligns the first tick one full ms after the wait begins
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else if (clr)
		begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
			tick_reg <= (cnt_reg == LAST);
		end
	end
endmodule // mpfs_ms_tick

//--- verilog/mpfs_sequencer.sv
// program flow sequencer of the stored-program interpreter
`timescale 1ns/100ps
module mpfs_sequencer #(
	parameter int ADDR_W = 8,
	parameter int IN_W = 8,
	parameter int CYC_PER_MS = mpfs_pkg::CYC_PER_MS
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [ADDR_W-1:0] start_line,
	input wire logic instr_valid,
	input wire mpfs_pkg::mpfs_op_t instr_op,
	input wire logic [$clog2(IN_W)-1:0] instr_port,
	input wire logic instr_level,
	input wire logic [mpfs_pkg::LABEL_W-1:0] instr_label,
	input wire logic [mpfs_pkg::TIME_W-1:0] instr_arg,
	input wire logic signed [mpfs_pkg::POS_W-1:0] instr_pos,
	input wire logic label_wr,
	input wire logic label_is_sub,
	input wire logic [mpfs_pkg::LABEL_W-1:0] label_num,
	input wire logic [ADDR_W-1:0] label_line,
	input wire logic [IN_W-1:0] in_ports,
	input wire logic signed [mpfs_pkg::POS_W-1:0] cur_pos,
	input wire logic motor_rotating,
	input wire logic dir_positive,
	input wire logic [mpfs_pkg::SPD_W-1:0] speed_sel_in,
	output logic running_reg,
	output logic [ADDR_W-1:0] prog_addr_reg,
	output logic fetch_req_reg,
	output logic decel_stop_req_reg,
	output logic speed_restore_reg,
	output logic [mpfs_pkg::SPD_W-1:0] speed_saved_reg,
	output logic nest_error_reg,
	output logic prog_done_reg
);
	// ****************************************
	// storage and decode
	// ****************************************
	localparam logic [mpfs_pkg::DEPTH_W-1:0] CALL_MAX = mpfs_pkg::DEPTH_W'(mpfs_pkg::CALL_DEPTH);
	localparam logic [mpfs_pkg::DEPTH_W-1:0] LOOP_MAX = mpfs_pkg::DEPTH_W'(mpfs_pkg::LOOP_DEPTH);
	localparam logic [mpfs_pkg::TIME_W-1:0] LAG_MS = mpfs_pkg::TIME_W'(mpfs_pkg::COND_LAG_MS);
	mpfs_pkg::mpfs_state_t state_reg;
	mpfs_pkg::mpfs_op_t op_reg;
	logic [$clog2(IN_W)-1:0] port_reg;
	logic level_reg;
	logic [mpfs_pkg::LABEL_W-1:0] label_reg;
	logic [mpfs_pkg::TIME_W-1:0] arg_reg;
	logic signed [mpfs_pkg::POS_W-1:0] pos_reg;
	logic [ADDR_W-1:0] jump_tab [0:(2**mpfs_pkg::LABEL_W)-1];
	logic [ADDR_W-1:0] sub_tab [0:(2**mpfs_pkg::SUB_IDX_W)-1];
	logic [ADDR_W-1:0] call_stack [0:mpfs_pkg::CALL_DEPTH-1];
	logic [ADDR_W-1:0] loop_start [0:mpfs_pkg::LOOP_DEPTH-1];
	logic [mpfs_pkg::LOOP_W-1:0] loop_cnt [0:mpfs_pkg::LOOP_DEPTH-1];
	logic [mpfs_pkg::DEPTH_W-1:0] call_sp_reg;
	logic [mpfs_pkg::DEPTH_W-1:0] loop_sp_reg;
	logic [mpfs_pkg::TIME_W-1:0] wait_cnt_reg;
	logic ms_tick;
	logic ms_clr;
	logic wait_over;
	logic in_hit;
	logic pos_hit;
	logic cond_hit;
	logic exec_err;
	logic [ADDR_W-1:0] next_line;
	logic [ADDR_W-1:0] jump_dest;
	logic [ADDR_W-1:0] sub_dest;
	logic [ADDR_W-1:0] ret_dest;
	logic [mpfs_pkg::DEPTH_W-1:0] call_top;
	logic [mpfs_pkg::DEPTH_W-1:0] loop_top;
	// shared decode of the latched line
	assign next_line = prog_addr_reg + 1'b1;
	assign jump_dest = jump_tab[label_reg];
	assign sub_dest = sub_tab[label_reg[mpfs_pkg::SUB_IDX_W-1:0]];
	assign call_top = call_sp_reg - 1'b1;
	assign loop_top = loop_sp_reg - 1'b1;
	assign ret_dest = call_stack[call_top];
	assign wait_over = ms_tick && (wait_cnt_reg <= 1);
	assign in_hit = (in_ports[port_reg] == level_reg);
	// strict pass in the direction of travel; a stopped motor never passes
	assign pos_hit = motor_rotating && (dir_positive ? (cur_pos > pos_reg) : (cur_pos < pos_reg));
	assign cond_hit = (op_reg == mpfs_pkg::OP_INPUT_COND_BRANCH) ? in_hit : pos_hit;
	// nesting beyond three levels or an unmatched return ends the program
	assign exec_err = ((op_reg == mpfs_pkg::OP_SUB_CALL) && (call_sp_reg == CALL_MAX))
		|| ((op_reg == mpfs_pkg::OP_SUB_RETURN) && (call_sp_reg == '0))
		|| ((op_reg == mpfs_pkg::OP_LOOP_BEGIN) && (loop_sp_reg == LOOP_MAX))
		|| ((op_reg == mpfs_pkg::OP_LOOP_CLOSE) && (loop_sp_reg == '0));
	assign ms_clr = (state_reg == mpfs_pkg::S_EXEC);
	mpfs_ms_tick #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_ms_tick (
		.ref_clk(ref_clk),
		.rst(rst),
		.clr(ms_clr),
		.tick_reg(ms_tick)
	);
	// loaded by the program writer; label zero is never a valid target
	always_ff @(posedge ref_clk)
	begin
		if (label_wr && (label_num != '0))
		begin
			if (!label_is_sub)
				jump_tab[label_num] <= label_line;
			else if (label_num <= mpfs_pkg::SUB_LABELS)
				sub_tab[label_num[mpfs_pkg::SUB_IDX_W-1:0]] <= label_line;
		end
	end
	// ****************************************
	// line pointer, state and stacks
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= mpfs_pkg::S_IDLE;
			prog_addr_reg <= '0;
			call_sp_reg <= '0;
			loop_sp_reg <= '0;
			op_reg <= mpfs_pkg::OP_NOP;
			port_reg <= '0;
			level_reg <= 1'b0;
			label_reg <= '0;
			arg_reg <= '0;
			pos_reg <= '0;
		end
		else
		begin
			case (state_reg)
				mpfs_pkg::S_IDLE:
					if (start)
					begin
						prog_addr_reg <= start_line;
						call_sp_reg <= '0;
						loop_sp_reg <= '0;
						state_reg <= mpfs_pkg::S_ISSUE;
					end
				mpfs_pkg::S_ISSUE: state_reg <= mpfs_pkg::S_FETCH;
				mpfs_pkg::S_FETCH:
					if (instr_valid)
					begin
						op_reg <= instr_op;
						port_reg <= instr_port;
						level_reg <= instr_level;
						label_reg <= instr_label;
						arg_reg <= instr_arg;
						pos_reg <= instr_pos;
						state_reg <= mpfs_pkg::S_EXEC;
					end
				mpfs_pkg::S_EXEC:
				begin
					state_reg <= mpfs_pkg::S_ISSUE;
					if (exec_err)
						state_reg <= mpfs_pkg::S_STOP;
					else
						case (op_reg)
							mpfs_pkg::OP_UNCOND_BRANCH: prog_addr_reg <= jump_dest;
							mpfs_pkg::OP_SUB_CALL:
							begin
								call_stack[call_sp_reg] <= next_line;
								call_sp_reg <= call_sp_reg + 1'b1;
								prog_addr_reg <= sub_dest;
							end
							mpfs_pkg::OP_SUB_RETURN:
							begin
								call_sp_reg <= call_top;
								prog_addr_reg <= ret_dest;
							end
							mpfs_pkg::OP_LOOP_BEGIN:
							begin
								loop_start[loop_sp_reg] <= next_line;
								loop_cnt[loop_sp_reg] <= arg_reg[mpfs_pkg::LOOP_W-1:0];
								loop_sp_reg <= loop_sp_reg + 1'b1;
								prog_addr_reg <= next_line;
							end
							mpfs_pkg::OP_LOOP_CLOSE:
								// a count of zero behaves as one pass
								if (loop_cnt[loop_top] > 1)
								begin
									loop_cnt[loop_top] <= loop_cnt[loop_top] - 1'b1;
									prog_addr_reg <= loop_start[loop_top];
								end
								else
								begin
									loop_sp_reg <= loop_top;
									prog_addr_reg <= next_line;
								end
							mpfs_pkg::OP_TIMER: state_reg <= mpfs_pkg::S_WAIT;
							mpfs_pkg::OP_INPUT_COND_BRANCH,
							mpfs_pkg::OP_POSITION_COND_BRANCH:
								state_reg <= mpfs_pkg::S_COND;
							mpfs_pkg::OP_PROG_END: state_reg <= mpfs_pkg::S_STOP;
							default:
								prog_addr_reg <= next_line;
						endcase
				end
				mpfs_pkg::S_WAIT:
					if (wait_over)
					begin
						prog_addr_reg <= next_line;
						state_reg <= mpfs_pkg::S_ISSUE;
					end
				mpfs_pkg::S_COND:
					if (wait_over)
					begin
						prog_addr_reg <= cond_hit ? jump_dest : next_line;
						state_reg <= mpfs_pkg::S_ISSUE;
					end
				mpfs_pkg::S_STOP:
					if (!motor_rotating)
						state_reg <= mpfs_pkg::S_FINISH;
				default: state_reg <= mpfs_pkg::S_IDLE;
			endcase
		end
	end
	// ms base restarts in exec, so a wait of n >= 1 lasts n ms plus one cycle
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			wait_cnt_reg <= '0;
		else if (state_reg == mpfs_pkg::S_EXEC)
			wait_cnt_reg <= (op_reg == mpfs_pkg::OP_TIMER) ? arg_reg : LAG_MS;
		else if (ms_tick && (wait_cnt_reg != '0))
			wait_cnt_reg <= wait_cnt_reg - 1'b1;
	end
	// ****************************************
	// status and drive side outputs
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			running_reg <= 1'b0;
			fetch_req_reg <= 1'b0;
			decel_stop_req_reg <= 1'b0;
			speed_restore_reg <= 1'b0;
			speed_saved_reg <= '0;
			nest_error_reg <= 1'b0;
			prog_done_reg <= 1'b0;
		end
		else
		begin
			fetch_req_reg <= (state_reg == mpfs_pkg::S_ISSUE);
			decel_stop_req_reg <= (state_reg == mpfs_pkg::S_STOP) && motor_rotating;
			speed_restore_reg <= (state_reg == mpfs_pkg::S_FINISH);
			prog_done_reg <= (state_reg == mpfs_pkg::S_FINISH);
			if ((state_reg == mpfs_pkg::S_IDLE) && start)
			begin
				running_reg <= 1'b1;
				speed_saved_reg <= speed_sel_in;
				nest_error_reg <= 1'b0;
			end
			else if (state_reg == mpfs_pkg::S_FINISH)
				running_reg <= 1'b0;
			if ((state_reg == mpfs_pkg::S_EXEC) && exec_err)
				nest_error_reg <= 1'b1;
		end
	end
	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	call_depth_a: assert property ((state_reg == mpfs_pkg::S_EXEC) && (op_reg == mpfs_pkg::OP_SUB_CALL) && (call_sp_reg == CALL_MAX) |=> nest_error_reg && (state_reg == mpfs_pkg::S_STOP) && (call_sp_reg == CALL_MAX)) else $error("call depth over three");
	loop_depth_a: assert property ((state_reg == mpfs_pkg::S_EXEC) && (op_reg == mpfs_pkg::OP_LOOP_BEGIN) && (loop_sp_reg == LOOP_MAX) |=> nest_error_reg && (state_reg == mpfs_pkg::S_STOP) && (loop_sp_reg == LOOP_MAX)) else $error("loop depth over three");
	branch_dest_a: assert property ((state_reg == mpfs_pkg::S_EXEC) && !exec_err && (op_reg == mpfs_pkg::OP_UNCOND_BRANCH) |=> (prog_addr_reg == $past(jump_dest)) ##1 fetch_req_reg) else $error("branch target wrong");
	return_dest_a: assert property ((state_reg == mpfs_pkg::S_EXEC) && !exec_err && (op_reg == mpfs_pkg::OP_SUB_RETURN) |=> (prog_addr_reg == $past(ret_dest)) && (call_sp_reg == $past(call_top))) else $error("return point wrong");
	cond_eval_a: assert property ((state_reg == mpfs_pkg::S_COND) && wait_over |=> (prog_addr_reg == ($past(cond_hit) ? $past(jump_dest) : $past(next_line)))) else $error("conditional branch wrong");
	pos_stopped_a: assert property ((state_reg == mpfs_pkg::S_COND) && wait_over && (op_reg == mpfs_pkg::OP_POSITION_COND_BRANCH) && !motor_rotating |=> (prog_addr_reg == $past(next_line))) else $error("stopped motor branched");
	timer_hold_a: assert property ((state_reg == mpfs_pkg::S_WAIT) && !wait_over |=> (state_reg == mpfs_pkg::S_WAIT) && $stable(prog_addr_reg)) else $error("timer left early");
	end_decel_a: assert property ((state_reg == mpfs_pkg::S_STOP) && motor_rotating |=> decel_stop_req_reg && running_reg) else $error("no decel at end");
	speed_back_a: assert property ((state_reg == mpfs_pkg::S_FINISH) |=> speed_restore_reg && prog_done_reg && !running_reg) else $error("speed not restored");
	plain_step_a: assert property ((state_reg == mpfs_pkg::S_EXEC) && (op_reg == mpfs_pkg::OP_NOP) |=> (prog_addr_reg == $past(prog_addr_reg) + 1'b1)) else $error("line not advanced");
	call_seen_c: cover property ((state_reg == mpfs_pkg::S_EXEC) && (op_reg == mpfs_pkg::OP_SUB_CALL) && !exec_err);
	loop_again_c: cover property ((state_reg == mpfs_pkg::S_EXEC) && (op_reg == mpfs_pkg::OP_LOOP_CLOSE) && (loop_sp_reg != '0) && (loop_cnt[loop_top] > 1));
	timer_done_c: cover property ((state_reg == mpfs_pkg::S_WAIT) && wait_over);
	end_decel_c: cover property (decel_stop_req_reg ##1 (state_reg == mpfs_pkg::S_FINISH));
endmodule // mpfs_sequencer
